// ==== rtl/fsc_pkg.sv ====
// Constants, field layout and carrier types for the configuration loader.
// Assumes one 10 MHz core clock and a programmer whose strobes are synchronous to it.
package fsc_pkg;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int CLK_NS    = 100;
   localparam int PULSE_NS  = 250;
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_W    = 2;

   // ********************************************************************
   // Field positions, programmed level and defaults
   // ********************************************************************
   localparam logic PROGRAMMED = 1'b0;
   localparam int EXT_SECOND_FORCE   = 7;
   localparam int EXT_SECOND_AUX     = 6;
   localparam int EXT_REDUCED_FORCE  = 5;
   localparam int EXT_POLARITY       = 4;
   localparam int EXT_INPUT_PULLUP   = 3;
   localparam int EXT_BROWNOUT_LSB   = 0;
   localparam int HIGH_EXT_RST_DIS   = 7;
   localparam int HIGH_DEBUG         = 6;
   localparam int HIGH_SERIAL_PROG   = 5;
   localparam int HIGH_WATCHDOG      = 4;
   localparam int HIGH_PRESERVE      = 3;
   localparam int HIGH_BOOT_LSB      = 1;
   localparam int HIGH_RESET_VECTOR  = 0;
   localparam int LOW_CLK_DIV8       = 7;
   localparam int LOW_CLK_OUT        = 6;
   localparam int LOW_STARTUP_LSB    = 4;
   localparam int LOW_CLK_SRC_LSB    = 0;

   localparam logic [7:0] EXT_DEFAULT  = 8'hfd;
   localparam logic [7:0] HIGH_DEFAULT = 8'hd9;
   localparam logic [7:0] LOW_DEFAULT  = 8'h62;
   localparam logic [7:0] KEEP_NONE    = 8'h00;
   localparam logic [7:0] KEEP_SERIAL  = 8'h01 << HIGH_SERIAL_PROG;

   // ********************************************************************
   // Signature row
   // ********************************************************************
   localparam logic [2:0] SIG_MAKER = 3'h0;
   localparam logic [2:0] SIG_SIZE  = 3'h2;
   localparam logic [2:0] SIG_TRIM  = 3'h3;
   localparam logic [2:0] SIG_PART  = 3'h4;
   localparam logic [7:0] SIG_EMPTY = 8'hff;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef enum logic [1:0] {
      SEL_LOW  = 2'h0,
      SEL_HIGH = 2'h1,
      SEL_EXT  = 2'h2
   } fsc_sel_t;

   typedef enum logic [2:0] {
      OP_NONE       = 3'h0,
      OP_WRITE_FUSE = 3'h1,
      OP_READ_FUSE  = 3'h2,
      OP_READ_SIG   = 3'h3,
      OP_CHIP_ERASE = 3'h4
   } fsc_op_t;

   typedef enum logic [1:0] {
      MODE_BOOT = 2'b00,
      MODE_RUN  = 2'b01,
      MODE_PROG = 2'b11
   } fsc_mode_t;

   typedef struct packed {
      logic [7:0] ext;
      logic [7:0] high;
      logic [7:0] low;
   } fsc_fuse_set_t;

   typedef struct packed {
      logic       stb;
      fsc_op_t    op;
      fsc_sel_t   sel;
      logic [2:0] addr;
      logic [7:0] data;
   } fsc_req_t;

   typedef struct packed {
      logic       rd_valid;
      logic [7:0] rd_data;
   } fsc_rsp_t;

   typedef struct packed {
      logic       second_stage_reset_force;
      logic       second_stage_aux_reset_force;
      logic       reduced_stage_reset_force;
      logic       stage_output_reset_polarity;
      logic       stage_input_reset_pullup;
      logic [2:0] brownout_trigger_level;
      logic       external_reset_disable;
      logic       onchip_debug_enable;
      logic       serial_programming_enable;
      logic       watchdog_always_on;
      logic       data_memory_preserve;
      logic [1:0] boot_area_size;
      logic       reset_vector_select;
      logic       clock_divide_by_eight;
      logic       system_clock_output_enable;
      logic [1:0] startup_time_select;
      logic [3:0] clock_source_select;
   } fsc_cfg_t;

   typedef struct packed {
      logic reduced;
      logic second;
      logic second_aux;
      logic level;
      logic input_pullup;
   } fsc_force_t;

   function automatic fsc_cfg_t fsc_decode(input fsc_fuse_set_t f);
      fsc_cfg_t c;
      c.second_stage_reset_force     = f.ext[EXT_SECOND_FORCE];
      c.second_stage_aux_reset_force = f.ext[EXT_SECOND_AUX];
      c.reduced_stage_reset_force    = f.ext[EXT_REDUCED_FORCE];
      c.stage_output_reset_polarity  = f.ext[EXT_POLARITY];
      c.stage_input_reset_pullup     = f.ext[EXT_INPUT_PULLUP];
      c.brownout_trigger_level       = f.ext[EXT_BROWNOUT_LSB +: 3];
      c.external_reset_disable       = f.high[HIGH_EXT_RST_DIS];
      c.onchip_debug_enable          = f.high[HIGH_DEBUG];
      c.serial_programming_enable    = f.high[HIGH_SERIAL_PROG];
      c.watchdog_always_on           = f.high[HIGH_WATCHDOG];
      c.data_memory_preserve         = f.high[HIGH_PRESERVE];
      c.boot_area_size               = f.high[HIGH_BOOT_LSB +: 2];
      c.reset_vector_select          = f.high[HIGH_RESET_VECTOR];
      c.clock_divide_by_eight        = f.low[LOW_CLK_DIV8];
      c.system_clock_output_enable   = f.low[LOW_CLK_OUT];
      c.startup_time_select          = f.low[LOW_STARTUP_LSB +: 2];
      c.clock_source_select          = f.low[LOW_CLK_SRC_LSB +: 4];
      return c;
   endfunction : fsc_decode

   localparam fsc_fuse_set_t FUSE_DEFAULT = '{EXT_DEFAULT, HIGH_DEFAULT, LOW_DEFAULT};
   localparam fsc_cfg_t      CFG_RESET    = fsc_decode(FUSE_DEFAULT);

   typedef struct packed {
      fsc_mode_t         mode;
      logic [HOLD_W-1:0] hold_cnt;
      fsc_cfg_t          cfg;
      fsc_force_t        force_out;
      logic [7:0]        osc_cal;
      fsc_rsp_t          rsp;
      logic              preserve;
      logic              erase;
      logic              eeprom_erase;
   } fsc_state_t;

endpackage : fsc_pkg

// ==== rtl/fsc_fuse_store.sv ====
// Raw configuration bytes and the read-only signature row.
// Assumes writes arrive already qualified by the loader; sys_rst models factory state.
`timescale 1ns/1ns
module fsc_fuse_store
   import fsc_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h5a,
   parameter logic [7:0] SIZE_ID  = 8'h3c,
   parameter logic [7:0] PART_ID  = 8'h69,
   parameter logic [7:0] TRIM     = 8'h80
)
(
   input  wire logic           core_clk,
   input  wire logic           sys_rst,
   input  wire logic           wr_en,
   input  wire fsc_sel_t       wr_sel,
   input  wire logic [7:0]     wr_data,
   input  wire logic [7:0]     wr_keep,
   input  wire logic [2:0]     sig_addr,
   output fsc_pkg::fsc_fuse_set_t fuses,
   output logic [7:0]          sig_data,
   output logic [7:0]          trim
);

   fsc_fuse_set_t s_q;
   fsc_fuse_set_t s_d;

   // ********************************************************************
   // Signature lookup
   // ********************************************************************
   function automatic logic [7:0] sig_byte(input logic [2:0] a);
      case (a)
         SIG_MAKER: sig_byte = MAKER_ID;
         SIG_SIZE:  sig_byte = SIZE_ID;
         SIG_TRIM:  sig_byte = TRIM;
         SIG_PART:  sig_byte = PART_ID;
         default:   sig_byte = SIG_EMPTY;
      endcase
   endfunction : sig_byte

   function automatic logic [7:0] merge(input logic [7:0] old_v,
                                        input logic [7:0] new_v,
                                        input logic [7:0] keep);
      merge = (old_v & keep) | (new_v & ~keep);
   endfunction : merge

   // ********************************************************************
   // Storage
   // ********************************************************************
   always_comb
   begin
      s_d = s_q;
      if (wr_en)
      begin
         case (wr_sel)
            SEL_LOW:  s_d.low  = merge(s_q.low, wr_data, wr_keep);
            SEL_HIGH: s_d.high = merge(s_q.high, wr_data, wr_keep);
            SEL_EXT:  s_d.ext  = merge(s_q.ext, wr_data, wr_keep);
            default:  s_d = s_q;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         s_q <= FUSE_DEFAULT;
      else
         s_q <= s_d;
   end

   assign fuses    = s_q;
   assign sig_data = sig_byte(sig_addr);
   assign trim     = sig_byte(SIG_TRIM);

endmodule : fsc_fuse_store

// ==== rtl/fsc_config.sv ====
// Configuration loader: latches the configuration bytes, forces stage pins in reset,
// loads the oscillator trim and serves programmer reads and writes.
// Assumes all inputs are synchronous to core_clk; dev_rst is the chip reset level.
`timescale 1ns/1ns

// Overview of operation
// - Each configuration bit reads 0 when programmed, 1 when unprogrammed.
// - Forced stage outputs go low if polarity bit programmed, else high.
// - Reduced-stage force holds both outputs until first stage control written.
// - Second-stage force holds outputs 0 and 1 until its control written.
// - Auxiliary force holds second-stage outputs 2 and 3 likewise.
// - Input pull-ups forced only during reset; input B never affected.
// - Extended byte bits 2..0 hold brown-out level, default 101.
// - High byte holds reset disable, debug, serial enable, watchdog fields.
// - Serial programming enable bit cannot change in serial programming mode.
// - Programmed preserve bit keeps data memory through chip erase.
// - High bits 2..1 boot size, default largest; bit 0 reset vector.
// - Low byte bit 7 clock divide by eight, bit 6 clock output.
// - Low bits 5..4 start-up, 3..0 clock source; defaults 10, 0010.
// - Chip erase leaves every configuration bit unchanged.
// - Writes refused once the first lock bit is programmed.
// - Values latched on programming entry; changes act only after exit.
// - Preserve bit takes effect immediately once programmed.
// - Values also latched at power-up in normal mode.
// - Three signature bytes at 0, 2, 4 readable even when locked.
// - Trim byte at signature address 3 copied to calibration during reset.
module fsc_config
   import fsc_pkg::*;
#(
   parameter int         HOLD_CYC = PULSE_CYC,
   parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
   parameter logic [7:0] SIZE_ID  = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_ID  = 8'h69, // Arbitrary value
   parameter logic [7:0] TRIM     = 8'h80
)
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       prog_mode,
   input  wire logic       prog_serial,
   input  wire logic       first_lock_bit,
   input  wire logic       dev_rst,
   input  wire logic       first_stage_ctl_wr,
   input  wire logic       second_stage_ctl_wr,
   input  fsc_pkg::fsc_req_t prog_req,
   output fsc_pkg::fsc_rsp_t prog_rsp,
   output fsc_pkg::fsc_cfg_t cfg,
   output fsc_pkg::fsc_force_t stage_force,
   output logic [7:0]      osc_cal,
   output logic            preserve_active,
   output logic            chip_erase_pulse,
   output logic            eeprom_erase_pulse
);
   import fsc_pkg::*;

   // ********************************************************************
   // Elaboration checks
   // ********************************************************************
   if (HOLD_CYC < 1 || HOLD_CYC >= (1 << HOLD_W))
   begin : g_bad_hold
      $error("HOLD_CYC out of range for the hold counter");
   end

   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);
   localparam logic [HOLD_W-1:0] HOLD_SAT  = HOLD_W'(HOLD_CYC);
   localparam logic [HOLD_W-1:0] HOLD_ONE  = HOLD_W'(1);

   fsc_state_t    s_q;
   fsc_state_t    s_d;
   fsc_fuse_set_t fuses;
   logic [7:0]    sig_data;
   logic [7:0]    trim;
   logic          take;
   logic          latch;
   logic          wr_en;
   logic [7:0]    wr_keep;

   function automatic logic [7:0] pick_byte(input fsc_fuse_set_t f, input fsc_sel_t s);
      case (s)
         SEL_LOW:  pick_byte = f.low;
         SEL_HIGH: pick_byte = f.high;
         SEL_EXT:  pick_byte = f.ext;
         default:  pick_byte = SIG_EMPTY;
      endcase
   endfunction : pick_byte

   // ********************************************************************
   // Raw storage and signature row
   // ********************************************************************
   fsc_fuse_store #(
      .MAKER_ID (MAKER_ID),
      .SIZE_ID  (SIZE_ID),
      .PART_ID  (PART_ID),
      .TRIM     (TRIM)
   ) u_store (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_en    (wr_en),
      .wr_sel   (prog_req.sel),
      .wr_data  (prog_req.data),
      .wr_keep  (wr_keep),
      .sig_addr (prog_req.addr),
      .fuses    (fuses),
      .sig_data (sig_data),
      .trim     (trim)
   );

   // ********************************************************************
   // Strobe qualification and write gating
   // ********************************************************************
   // Strobe must stand for HOLD_CYC edges; glitches never reach storage
   assign take = prog_req.stb && (s_q.hold_cnt == HOLD_LAST) && (s_q.mode == MODE_PROG);
   assign wr_en = take && (prog_req.op == OP_WRITE_FUSE)
                  && (first_lock_bit != PROGRAMMED);
   // Serial mode cannot touch its own enable, else the part could lock itself out
   assign wr_keep = (prog_serial && prog_req.sel == SEL_HIGH) ? KEEP_SERIAL : KEEP_NONE;

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb
   begin
      s_d = s_q;
      latch = 1'b0;
      s_d.rsp.rd_valid = 1'b0;
      s_d.erase = 1'b0;
      s_d.eeprom_erase = 1'b0;

      if (!prog_req.stb)
         s_d.hold_cnt = '0;
      else if (s_q.hold_cnt != HOLD_SAT)
         s_d.hold_cnt = s_q.hold_cnt + HOLD_ONE;

      case (s_q.mode)
         MODE_BOOT:
         begin
            latch = 1'b1;
            s_d.mode = prog_mode ? MODE_PROG : MODE_RUN;
         end
         MODE_RUN:
         begin
            if (prog_mode)
            begin
               latch = 1'b1;
               s_d.mode = MODE_PROG;
            end
         end
         MODE_PROG:
         begin
            if (!prog_mode)
            begin
               latch = 1'b1;
               s_d.mode = MODE_RUN;
            end
         end
         default:
            s_d.mode = MODE_BOOT;
      endcase

      if (latch)
         s_d.cfg = fsc_decode(fuses);

      // Preserve acts on raw storage too, so it needs no latch event
      s_d.preserve = (s_q.cfg.data_memory_preserve == PROGRAMMED)
                     || (fuses.high[HIGH_PRESERVE] == PROGRAMMED);

      if (take)
      begin
         case (prog_req.op)
            OP_READ_FUSE:
            begin
               s_d.rsp.rd_valid = 1'b1;
               s_d.rsp.rd_data = pick_byte(fuses, prog_req.sel);
            end
            OP_READ_SIG:
            begin
               s_d.rsp.rd_valid = 1'b1;
               s_d.rsp.rd_data = sig_data;
            end
            OP_CHIP_ERASE:
            begin
               s_d.erase = 1'b1;
               s_d.eeprom_erase = !s_q.preserve;
            end
            default:
               s_d.rsp.rd_valid = 1'b0;
         endcase
      end

      // Forcing starts in reset; control writes in reset cannot release it
      s_d.force_out.level = s_q.cfg.stage_output_reset_polarity;
      s_d.force_out.input_pullup = dev_rst
                                   && (s_q.cfg.stage_input_reset_pullup == PROGRAMMED);
      if (dev_rst)
      begin
         s_d.force_out.reduced = (s_q.cfg.reduced_stage_reset_force == PROGRAMMED);
         s_d.force_out.second = (s_q.cfg.second_stage_reset_force == PROGRAMMED);
         s_d.force_out.second_aux = (s_q.cfg.second_stage_aux_reset_force == PROGRAMMED);
         s_d.osc_cal = trim;
      end
      else
      begin
         if (first_stage_ctl_wr)
            s_d.force_out.reduced = 1'b0;
         if (second_stage_ctl_wr)
         begin
            s_d.force_out.second = 1'b0;
            s_d.force_out.second_aux = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_q.mode <= MODE_BOOT;
         s_q.hold_cnt <= '0;
         s_q.cfg <= CFG_RESET;
         // Idle level matches the reset polarity so no level step follows release
         s_q.force_out <= '{reduced:      1'b0,
                            second:       1'b0,
                            second_aux:   1'b0,
                            level:        CFG_RESET.stage_output_reset_polarity,
                            input_pullup: 1'b0};
         // Power-up reset is a reset too, so the trim is in place at release
         s_q.osc_cal <= TRIM;
         s_q.rsp <= '0;
         s_q.preserve <= 1'b0;
         s_q.erase <= 1'b0;
         s_q.eeprom_erase <= 1'b0;
      end
      else
         s_q <= s_d;
   end

   assign prog_rsp           = s_q.rsp;
   assign cfg                = s_q.cfg;
   assign stage_force        = s_q.force_out;
   assign osc_cal            = s_q.osc_cal;
   assign preserve_active    = s_q.preserve;
   assign chip_erase_pulse   = s_q.erase;
   assign eeprom_erase_pulse = s_q.eeprom_erase;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_take_write;
      take && prog_req.op == OP_WRITE_FUSE;
   endsequence

   sequence s_take_sig0;
      take && prog_req.op == OP_READ_SIG && prog_req.addr == SIG_MAKER;
   endsequence

   a_strobe_min_width: assert property (take |-> $past(prog_req.stb, 1) && $past(prog_req.stb, 2))
      else $error("strobe taken before its minimum width");

   a_locked_no_write: assert property ((s_take_write ##0 first_lock_bit == PROGRAMMED)
      |=> $stable(fuses))
      else $error("configuration changed while locked");

   a_erase_keeps_bytes: assert property (take && prog_req.op == OP_CHIP_ERASE
      |=> $stable(fuses) ##0 chip_erase_pulse)
      else $error("chip erase disturbed configuration");

   a_serial_bit_kept: assert property ((s_take_write ##0 prog_serial)
      |=> fuses.high[HIGH_SERIAL_PROG] == $past(fuses.high[HIGH_SERIAL_PROG]))
      else $error("serial enable changed in serial mode");

   a_cfg_static: assert property (!latch |=> $stable(cfg))
      else $error("configuration outputs moved without a latch event");

   a_cfg_prog_hold: assert property (s_q.mode == MODE_PROG && prog_mode
      |=> $stable(cfg))
      else $error("configuration moved during programming");

   a_reduced_force_hold: assert property (stage_force.reduced && !first_stage_ctl_wr
      |=> stage_force.reduced)
      else $error("reduced stage force released early");

   a_second_force_set: assert property (dev_rst && cfg.second_stage_reset_force == PROGRAMMED
      |=> stage_force.second)
      else $error("second stage force not applied in reset");

   a_aux_force_release: assert property (!dev_rst && second_stage_ctl_wr
      |=> !stage_force.second_aux)
      else $error("auxiliary force not released by control write");

   a_force_level: assert property (##1 stage_force.level == $past(cfg.stage_output_reset_polarity))
      else $error("forced level does not follow polarity");

   a_pullup_reset_only: assert property (stage_force.input_pullup |-> $past(dev_rst))
      else $error("input pull-up forced outside reset");

   a_trim_load: assert property (dev_rst |=> osc_cal == TRIM)
      else $error("calibration not loaded in reset");

   a_sig_read: assert property (s_take_sig0 |=> prog_rsp.rd_valid && prog_rsp.rd_data == MAKER_ID)
      else $error("signature byte 0 read wrong");

   a_preserve_now: assert property (fuses.high[HIGH_PRESERVE] == PROGRAMMED |=> preserve_active)
      else $error("preserve not effective immediately");

endmodule : fsc_config

// ==== tb/fsc_prog_model.sv ====
// Programmer model: drives strobed requests into the loader's programming port.
// Assumes the loader samples requests on rising core_clk edges.
`timescale 1ns/1ns
module fsc_prog_model
(
   input  wire logic         core_clk,
   output fsc_pkg::fsc_req_t prog_req
);
   import fsc_pkg::*;
   initial prog_req = '0;
   // Fields stand through the whole strobe; on release address and data are inverted, op and sel are left as sent
   task automatic send(input fsc_op_t op, input fsc_sel_t s, input logic [2:0] a,
                       input logic [7:0] d, input int len);
      @(posedge core_clk);
      prog_req <= '{1'b1, op, s, a, d};
      repeat (len) @(posedge core_clk);
      // Return at the release edge so a one-cycle answer is still visible
      prog_req <= '{1'b0, op, s, ~a, ~d};
   endtask : send
endmodule : fsc_prog_model

// ==== tb/tb_fuse_signature_config.sv ====
// Self-checking bench for the configuration loader, driven through a programmer model.
// Assumes the default three-cycle strobe qualification of the loader.
`timescale 1ns/1ns
module tb_fuse_signature_config;
   import fsc_pkg::*;
   localparam int         HOLD    = 3;
   localparam logic [7:0] SIG [5] = '{8'h5a, 8'hff, 8'h3c, 8'h80, 8'h69}; // Arbitrary ids
   logic       core_clk, sys_rst, prog_mode, prog_serial, first_lock_bit, dev_rst;
   logic       first_stage_ctl_wr, second_stage_ctl_wr;
   logic       preserve_active, chip_erase_pulse, eeprom_erase_pulse;
   logic [7:0] osc_cal, r;
   fsc_req_t   prog_req;
   fsc_rsp_t   prog_rsp;
   fsc_cfg_t   cfg;
   fsc_force_t stage_force;
   int         err_total, total_checks, cyc;
   int         st [3];
   int         lat [3];

   fsc_config #(.HOLD_CYC(HOLD), .MAKER_ID(SIG[0]), .SIZE_ID(SIG[2]), .TRIM(SIG[3]),
      .PART_ID(SIG[4])) uut (.core_clk, .sys_rst, .prog_mode, .prog_serial,
      .first_lock_bit, .dev_rst, .first_stage_ctl_wr, .second_stage_ctl_wr, .prog_req,
      .prog_rsp, .cfg, .stage_force, .osc_cal, .preserve_active, .chip_erase_pulse,
      .eeprom_erase_pulse);
   fsc_prog_model pm (.core_clk, .prog_req);

   initial
   begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic end_sim;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         end_sim();
      end
   end

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic chk_cfg(input fsc_cfg_t g);
      logic [23:0] e;
      e = {lat[2][7:0], lat[1][7:0], lat[0][7:0]};
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_cfg

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic rd(input fsc_op_t op, input int s, input int len);
      pm.send(op, fsc_sel_t'(s[1:0]), s[2:0], 8'h00, len);
      #1;
      r = prog_rsp.rd_data;
      chk({7'h0, prog_rsp.rd_valid}, {7'h0, len == HOLD});
   endtask : rd

   task automatic wr(input fsc_sel_t s, input logic [7:0] d);
      pm.send(OP_WRITE_FUSE, s, 3'h0, d, HOLD);
      if (prog_serial && s == SEL_HIGH)
         d[5] = st[1][5];
      if (first_lock_bit)
         st[s] = d;
   endtask : wr

   task automatic fuse_rb;
      for (int i = 0; i < 3; i++)
      begin
         rd(OP_READ_FUSE, i, HOLD);
         chk(r, st[i][7:0]);
      end
   endtask : fuse_rb

   initial
   begin
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      {sys_rst, dev_rst, first_lock_bit} = 3'h7;
      {prog_mode, prog_serial, first_stage_ctl_wr, second_stage_ctl_wr} = 4'h0;
      st = '{8'h62, 8'hd9, 8'hfd};
      lat = st;
      void'($urandom(9782));
      repeat (16) @(posedge core_clk);
      sys_rst <= 0;
      tick(3);
      chk_cfg(cfg);
      chk(osc_cal, SIG[3]);
      chk(stage_force, 8'h02);
      @(posedge core_clk) {prog_mode, dev_rst} <= 2'b10;
      tick(2);
      rd(OP_READ_SIG, 0, HOLD - 1);
      wr(SEL_EXT, 8'($urandom));
      wr(SEL_LOW, 8'($urandom));
      fuse_rb();
      chk_cfg(cfg);
      pm.send(OP_CHIP_ERASE, SEL_LOW, 3'h0, 8'h00, HOLD);
      #1;
      chk({chip_erase_pulse, eeprom_erase_pulse}, 8'h03);
      wr(SEL_HIGH, 8'hd1);
      tick(1);
      chk(preserve_active, 8'h01);
      pm.send(OP_CHIP_ERASE, SEL_LOW, 3'h0, 8'h00, HOLD);
      #1;
      chk({chip_erase_pulse, eeprom_erase_pulse}, 8'h02);
      fuse_rb();
      @(posedge core_clk) prog_mode <= 0;
      tick(3);
      lat = st;
      chk_cfg(cfg);
      @(posedge core_clk) {prog_mode, prog_serial} <= 2'b11;
      tick(2);
      wr(SEL_HIGH, 8'hf1);
      fuse_rb();
      @(posedge core_clk) {first_lock_bit, prog_serial} <= 2'b00;
      wr(SEL_LOW, 8'h00);
      fuse_rb();
      for (int i = 0; i < 5; i++)
      begin
         rd(OP_READ_SIG, i, HOLD);
         chk(r, SIG[i]);
      end
      @(posedge core_clk) first_lock_bit <= 1;
      wr(SEL_EXT, 8'h05);
      @(posedge core_clk) prog_mode <= 0;
      tick(3);
      lat = st;
      chk_cfg(cfg);
      @(posedge core_clk) dev_rst <= 1;
      tick(2);
      chk(stage_force, 8'h1d);
      @(posedge core_clk) dev_rst <= 0;
      tick(2);
      chk(stage_force, 8'h1c);
      @(posedge core_clk) first_stage_ctl_wr <= 1;
      @(posedge core_clk) first_stage_ctl_wr <= 0;
      tick(1);
      chk(stage_force, 8'h0c);
      @(posedge core_clk) second_stage_ctl_wr <= 1;
      @(posedge core_clk) second_stage_ctl_wr <= 0;
      tick(1);
      chk(stage_force, 8'h00);
      chk_cfg(cfg);
      end_sim();
   end
endmodule : tb_fuse_signature_config
